// *** inc/cipher_key_table_defines.vh ***
/*
 * Offsets, field positions, cipher codes and reset values of the cipher key table.
 * Assumes it is included by bare name from files under hdl/ with inc/ on the include path.
 */
`ifndef CIPHER_KEY_TABLE_DEFINES_VH
`define CIPHER_KEY_TABLE_DEFINES_VH

// Table placement in the register space (byte addresses)
`define KT_BASE_ADDR        16'h8800
`define KT_SPAN_BYTES       16'h1000
`define KT_ENTRY_SHIFT      5
`define KT_ENTRIES          128
`define KT_MIC_OFFSET       64

// Word index inside an entry
`define KT_W_KEY0           3'h0
`define KT_W_KEY1           3'h1
`define KT_W_KEY2           3'h2
`define KT_W_KEY3           3'h3
`define KT_W_KEY4           3'h4
`define KT_W_TYPE           3'h5
`define KT_W_MAC_LO         3'h6
`define KT_W_MAC_HI         3'h7

// Field positions
`define KT_HALF_MSB         15
`define KT_TYPE_MSB         2
`define KT_MAC_HI_MSB       14
`define KT_VALID_BIT        15

// Cipher type codes
`define KT_CT_WEP40         3'h0
`define KT_CT_WEP104        3'h1
`define KT_CT_RSVD          3'h2
`define KT_CT_WEP128        3'h3
`define KT_CT_TKIP          3'h4
`define KT_CT_AES_OCB       3'h5
`define KT_CT_AES_CCM       3'h6
`define KT_CT_DISABLE       3'h7

// Key lengths in bits per cipher type
`define KT_LEN_40           8'h28
`define KT_LEN_104          8'h68
`define KT_LEN_128          8'h80
`define KT_LEN_NONE         8'h00

// Reset values
`define KT_TYPE_RESET       3'h7
`define KT_VALID_RESET      1'b0

`endif

// *** hdl/key_entry_decode.v ***
/*
 * Decodes the cipher type and valid flag of one looked-up entry.
 * Assumes the caller supplies the raw fields of the addressed entry, combinationally.
 */
`timescale 1ns/1ps
`include "cipher_key_table_defines.vh"

module key_entry_decode (
    input  wire [6:0] i_index,
    input  wire       i_valid,
    input  wire [2:0] i_ctype,
    output reg        o_usable,
    output wire       o_is_tkip,
    output reg  [7:0] o_key_len
);

    // TKIP needs a partner slot, so only lower-half entries qualify
    assign o_is_tkip = i_valid && (i_ctype == `KT_CT_TKIP) && !i_index[6];

    // Usable only when valid and carrying a real cipher
    always @* begin
        o_key_len = `KT_LEN_NONE;
        o_usable  = 1'b0;
        case (i_ctype)
            `KT_CT_WEP40:   o_key_len = `KT_LEN_40;
            `KT_CT_WEP104:  o_key_len = `KT_LEN_104;
            `KT_CT_WEP128:  o_key_len = `KT_LEN_128;
            `KT_CT_TKIP:    o_key_len = `KT_LEN_128;
            `KT_CT_AES_OCB: o_key_len = `KT_LEN_128;
            `KT_CT_AES_CCM: o_key_len = `KT_LEN_128;
            default:        o_key_len = `KT_LEN_NONE; // Reserved or disabled
        endcase
        if (i_valid && (o_key_len != `KT_LEN_NONE)) begin
            o_usable = (i_ctype != `KT_CT_TKIP) || o_is_tkip;
        end
    end

endmodule

// *** hdl/cipher_key_table.v ***
/*
 * Cipher key table: 128 eight-word entries in the register space, with one
 * lookup port for the transmit path and one for the receive path.
 * Assumes register strobes and lookup requests come from logic on i_mclk.
 */
// What this block does
// - Holds 128 entries of key, cipher type, station address and valid flag.
// - Table starts at byte 0x8800; entry N starts 32*N bytes later.
// - Valid entries with a real cipher type supply keys to both transmit and receive lookups.
// - Key bits sit in words 0-4; upper halves of words 1 and 3 reserved.
// - Word 5 bits 2-0 hold the cipher type code.
// - Station address bits 32-1 in word 6, bits 47-33 in word 7.
// - Word 7 bit 15 marks key and address valid.
// - A valid TKIP entry takes its Michael key from entry index plus 64.
// - Entries 64-127 hold Michael keys in words 0 and 2, valid kept 0.
`timescale 1ns/1ps
`include "cipher_key_table_defines.vh"

module cipher_key_table (
    input  wire         i_mclk,
    input  wire         i_reset,
    input  wire         i_ce,
    input  wire         i_reg_wr,
    input  wire         i_reg_rd,
    input  wire [15:0]  i_reg_addr,
    input  wire [31:0]  i_reg_wdata,
    output wire [31:0]  o_reg_rdata,
    output wire         o_reg_rvalid,
    input  wire         i_tx_req,
    input  wire [6:0]   i_tx_index,
    output wire         o_tx_rsp,
    output wire         o_tx_hit,
    output wire         o_tx_tkip,
    output wire [2:0]   o_tx_ctype,
    output wire [7:0]   o_tx_key_len,
    output wire [127:0] o_tx_key,
    output wire [47:0]  o_tx_mac,
    output wire [31:0]  o_tx_mic0,
    output wire [31:0]  o_tx_mic1,
    input  wire         i_rx_req,
    input  wire [6:0]   i_rx_index,
    output wire         o_rx_rsp,
    output wire         o_rx_hit,
    output wire         o_rx_tkip,
    output wire [2:0]   o_rx_ctype,
    output wire [7:0]   o_rx_key_len,
    output wire [127:0] o_rx_key,
    output wire [47:0]  o_rx_mac,
    output wire [31:0]  o_rx_mic0,
    output wire [31:0]  o_rx_mic1
);

    parameter ENTRIES = `KT_ENTRIES;

    // Entry storage in flip-flops, one array per field
    reg  [31:0]        key0_ff   [0:ENTRIES-1];
    reg  [15:0]        key1_ff   [0:ENTRIES-1];
    reg  [31:0]        key2_ff   [0:ENTRIES-1];
    reg  [15:0]        key3_ff   [0:ENTRIES-1];
    reg  [31:0]        key4_ff   [0:ENTRIES-1];
    reg  [2:0]         ctype_ff  [0:ENTRIES-1];
    reg  [31:0]        mac_lo_ff [0:ENTRIES-1];
    reg  [14:0]        mac_hi_ff [0:ENTRIES-1];
    reg  [ENTRIES-1:0] valid_ff;
    reg  [31:0]        rdata_ff;
    reg                rvalid_ff;

    wire [15:0]        offset;
    wire               reg_hit;
    wire [6:0]         wr_entry;
    wire [2:0]         wr_word;
    reg  [31:0]        nxt_rdata;
    integer            i;

    // Address decode: aligned words inside the table window
    assign offset   = i_reg_addr - `KT_BASE_ADDR;
    assign reg_hit  = (i_reg_addr >= `KT_BASE_ADDR) && (offset < `KT_SPAN_BYTES) &&
                      (i_reg_addr[1:0] == 2'b00);
    assign wr_entry = offset[11:`KT_ENTRY_SHIFT];
    assign wr_word  = offset[4:2];

    // Read mux; reserved bits read as zero, unmapped reads return zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (reg_hit) begin
            case (wr_word)
                `KT_W_KEY0:   nxt_rdata = key0_ff[wr_entry];
                `KT_W_KEY1:   nxt_rdata = {16'h0000, key1_ff[wr_entry]};
                `KT_W_KEY2:   nxt_rdata = key2_ff[wr_entry];
                `KT_W_KEY3:   nxt_rdata = {16'h0000, key3_ff[wr_entry]};
                `KT_W_KEY4:   nxt_rdata = key4_ff[wr_entry];
                `KT_W_TYPE:   nxt_rdata = {29'h0000_0000, ctype_ff[wr_entry]};
                `KT_W_MAC_LO: nxt_rdata = mac_lo_ff[wr_entry];
                `KT_W_MAC_HI: nxt_rdata = {16'h0000, valid_ff[wr_entry],
                                           mac_hi_ff[wr_entry]};
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register read answer one cycle after the strobe
    always @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else if (i_ce) begin
            rvalid_ff <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign o_reg_rdata  = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;

    // Control fields: valid flags and cipher types, reset to invalid/disabled
    always @(posedge i_mclk) begin
        if (i_reset) begin
            valid_ff <= {ENTRIES{`KT_VALID_RESET}};
            for (i = 0; i < ENTRIES; i = i + 1) begin
                ctype_ff[i] <= `KT_TYPE_RESET;
            end
        end else if (i_ce && i_reg_wr && reg_hit) begin
            if (wr_word == `KT_W_TYPE) begin
                ctype_ff[wr_entry] <= i_reg_wdata[`KT_TYPE_MSB:0];
            end
            if (wr_word == `KT_W_MAC_HI) begin
                // Michael slots never become valid
                valid_ff[wr_entry] <= i_reg_wdata[`KT_VALID_BIT] & ~wr_entry[6];
            end
        end
    end

    // Key and address data, not reset; guarded by the valid flag
    always @(posedge i_mclk) begin
        if (i_ce && i_reg_wr && reg_hit) begin
            case (wr_word)
                `KT_W_KEY0:   key0_ff[wr_entry]   <= i_reg_wdata;
                `KT_W_KEY1:   key1_ff[wr_entry]   <= i_reg_wdata[`KT_HALF_MSB:0];
                `KT_W_KEY2:   key2_ff[wr_entry]   <= i_reg_wdata;
                `KT_W_KEY3:   key3_ff[wr_entry]   <= i_reg_wdata[`KT_HALF_MSB:0];
                `KT_W_KEY4:   key4_ff[wr_entry]   <= i_reg_wdata;
                `KT_W_MAC_LO: mac_lo_ff[wr_entry] <= i_reg_wdata;
                `KT_W_MAC_HI: mac_hi_ff[wr_entry] <= i_reg_wdata[`KT_MAC_HI_MSB:0];
                default:      ;
            endcase
        end
    end

    // Lookup ports: port 0 serves transmit, port 1 serves receive
    wire [1:0]   lk_req;
    wire [13:0]  lk_index;
    reg  [1:0]   rsp_ff;
    reg  [1:0]   hit_ff;
    reg  [1:0]   tkip_ff;
    reg  [5:0]   ctype_o_ff;
    reg  [15:0]  len_ff;
    reg  [255:0] key_ff;
    reg  [95:0]  mac_ff;
    reg  [63:0]  mic0_ff;
    reg  [63:0]  mic1_ff;

    assign lk_req   = {i_rx_req, i_tx_req};
    assign lk_index = {i_rx_index, i_tx_index};

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire [6:0] idx;
            wire [6:0] mic_idx;
            wire       usable;
            wire       is_tkip;
            wire [7:0] key_len;

            assign idx     = lk_index[7*p+6:7*p];
            assign mic_idx = {1'b1, idx[5:0]};

            key_entry_decode u_dec (
                .i_index   (idx),
                .i_valid   (valid_ff[idx]),
                .i_ctype   (ctype_ff[idx]),
                .o_usable  (usable),
                .o_is_tkip (is_tkip),
                .o_key_len (key_len)
            );

            // Registered answer; fields are zero and the cipher type reads disabled when the entry is not usable
            always @(posedge i_mclk) begin
                if (i_reset) begin
                    rsp_ff[p]              <= 1'b0;
                    hit_ff[p]              <= 1'b0;
                    tkip_ff[p]             <= 1'b0;
                    ctype_o_ff[3*p+2:3*p]  <= `KT_CT_DISABLE;
                    len_ff[8*p+7:8*p]      <= `KT_LEN_NONE;
                    key_ff[128*p+127:128*p] <= 128'h0;
                    mac_ff[48*p+47:48*p]   <= 48'h0;
                    mic0_ff[32*p+31:32*p]  <= 32'h0;
                    mic1_ff[32*p+31:32*p]  <= 32'h0;
                end else if (i_ce) begin
                    rsp_ff[p] <= lk_req[p];
                    if (lk_req[p]) begin
                        hit_ff[p]             <= usable;
                        tkip_ff[p]            <= usable & is_tkip;
                        ctype_o_ff[3*p+2:3*p] <= usable ? ctype_ff[idx] : `KT_CT_DISABLE;
                        len_ff[8*p+7:8*p]     <= usable ? key_len : `KT_LEN_NONE;
                        key_ff[128*p+127:128*p] <= usable ?
                            {key4_ff[idx], key3_ff[idx], key2_ff[idx],
                             key1_ff[idx], key0_ff[idx]} : 128'h0;
                        mac_ff[48*p+47:48*p]  <= usable ?
                            {mac_hi_ff[idx], mac_lo_ff[idx], 1'b0} : 48'h0;
                        mic0_ff[32*p+31:32*p] <= (usable & is_tkip) ?
                            key0_ff[mic_idx] : 32'h0;
                        mic1_ff[32*p+31:32*p] <= (usable & is_tkip) ?
                            key2_ff[mic_idx] : 32'h0;
                    end
                end
            end
        end
    endgenerate

    // Transmit-side outputs
    assign o_tx_rsp     = rsp_ff[0];
    assign o_tx_hit     = hit_ff[0];
    assign o_tx_tkip    = tkip_ff[0];
    assign o_tx_ctype   = ctype_o_ff[2:0];
    assign o_tx_key_len = len_ff[7:0];
    assign o_tx_key     = key_ff[127:0];
    assign o_tx_mac     = mac_ff[47:0];
    assign o_tx_mic0    = mic0_ff[31:0];
    assign o_tx_mic1    = mic1_ff[31:0];

    // Receive-side outputs
    assign o_rx_rsp     = rsp_ff[1];
    assign o_rx_hit     = hit_ff[1];
    assign o_rx_tkip    = tkip_ff[1];
    assign o_rx_ctype   = ctype_o_ff[5:3];
    assign o_rx_key_len = len_ff[15:8];
    assign o_rx_key     = key_ff[255:128];
    assign o_rx_mac     = mac_ff[95:48];
    assign o_rx_mic0    = mic0_ff[63:32];
    assign o_rx_mic1    = mic1_ff[63:32];

endmodule

// *** verif/cipher_key_table_properties.sv ***
/* Port checker for cipher_key_table: answers, miss zeroing, TKIP pairing.
   Assumes one clock i_mclk and a synchronous active-high i_reset. */
`timescale 1ns/1ps
module cipher_key_table_properties (
    input wire         i_mclk,
    input wire         i_reset,
    input wire         i_ce,
    input wire         i_reg_rd,
    input wire         o_reg_rvalid,
    input wire         i_tx_req,
    input wire [6:0]   i_tx_index,
    input wire         o_tx_rsp,
    input wire         o_tx_hit,
    input wire         o_tx_tkip,
    input wire [2:0]   o_tx_ctype,
    input wire [7:0]   o_tx_key_len,
    input wire [127:0] o_tx_key,
    input wire         i_rx_req,
    input wire         o_rx_rsp,
    input wire [47:0]  o_rx_mac
);
    // One clock domain for every property
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_rd_answer: assert property (i_ce && i_reg_rd |=> o_reg_rvalid)
        else $error("register read not answered");
    a_tx_answer: assert property (i_ce && i_tx_req |=> o_tx_rsp)
        else $error("transmit lookup not answered");
    a_rx_answer: assert property (i_ce && i_rx_req |=> o_rx_rsp)
        else $error("receive lookup not answered");
    a_miss_cleared: assert property (o_tx_rsp && !o_tx_hit |->
        o_tx_key == 128'h0 && o_tx_ctype == 3'h7 && o_tx_key_len == 8'h00)
        else $error("missed lookup left fields set");
    a_tkip_is_hit: assert property (o_tx_tkip |-> o_tx_hit && o_tx_ctype == 3'h4)
        else $error("tkip flag without tkip hit");
    a_upper_no_tkip: assert property (i_ce && i_tx_req && i_tx_index[6] |=> !o_tx_tkip)
        else $error("tkip used from upper half");
    a_len_matches: assert property (o_tx_hit |-> o_tx_key_len ==
        (o_tx_ctype == 3'h0 ? 8'h28 : o_tx_ctype == 3'h1 ? 8'h68 : 8'h80))
        else $error("key length does not match type");
    a_mac_lsb_zero: assert property (o_rx_rsp |-> o_rx_mac[0] == 1'b0)
        else $error("station address bit 0 set");
endmodule

bind cipher_key_table cipher_key_table_properties u_props (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_ce(i_ce), .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid),
    .i_tx_req(i_tx_req), .i_tx_index(i_tx_index), .o_tx_rsp(o_tx_rsp), .o_tx_hit(o_tx_hit),
    .o_tx_tkip(o_tx_tkip), .o_tx_ctype(o_tx_ctype), .o_tx_key_len(o_tx_key_len),
    .o_tx_key(o_tx_key), .i_rx_req(i_rx_req), .o_rx_rsp(o_rx_rsp), .o_rx_mac(o_rx_mac));

// *** verif/testbench.sv ***
/* Self-checking bench for cipher_key_table: register map and lookups.
   Assumes the design files and defines header are compiled first. */
`timescale 1ns/1ps
module testbench;
    reg          i_mclk = 1'b0;
    reg          i_reset = 1'b1;
    reg          i_ce = 1'b1;
    reg          i_reg_wr = 1'b0;
    reg          i_reg_rd = 1'b0;
    reg  [15:0]  i_reg_addr = 16'h0000;
    reg  [31:0]  i_reg_wdata = 32'h0;
    reg          i_tx_req = 1'b0;
    reg          i_rx_req = 1'b0;
    reg  [6:0]   i_tx_index = 7'h00;
    reg  [6:0]   i_rx_index = 7'h00;
    wire [31:0]  o_reg_rdata, o_tx_mic0, o_tx_mic1, o_rx_mic0, o_rx_mic1;
    wire         o_reg_rvalid, o_tx_rsp, o_tx_hit, o_tx_tkip, o_rx_rsp, o_rx_hit, o_rx_tkip;
    wire [2:0]   o_tx_ctype, o_rx_ctype;
    wire [7:0]   o_tx_key_len, o_rx_key_len;
    wire [127:0] o_tx_key, o_rx_key;
    wire [47:0]  o_tx_mac, o_rx_mac;
    integer      n_fail = 0;
    integer      compares = 0;
    integer      t;
    integer      k;
    reg          h;

    cipher_key_table DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_tx_req(i_tx_req), .i_tx_index(i_tx_index), .o_tx_rsp(o_tx_rsp),
        .o_tx_hit(o_tx_hit), .o_tx_tkip(o_tx_tkip), .o_tx_ctype(o_tx_ctype),
        .o_tx_key_len(o_tx_key_len), .o_tx_key(o_tx_key), .o_tx_mac(o_tx_mac),
        .o_tx_mic0(o_tx_mic0), .o_tx_mic1(o_tx_mic1), .i_rx_req(i_rx_req),
        .i_rx_index(i_rx_index), .o_rx_rsp(o_rx_rsp), .o_rx_hit(o_rx_hit),
        .o_rx_tkip(o_rx_tkip), .o_rx_ctype(o_rx_ctype), .o_rx_key_len(o_rx_key_len),
        .o_rx_key(o_rx_key), .o_rx_mac(o_rx_mac), .o_rx_mic0(o_rx_mic0),
        .o_rx_mic1(o_rx_mic1));

    // 40 MHz clock
    always #12.5 i_mclk = ~i_mclk;

    // Byte address of word w of entry n
    function [15:0] ad(input [6:0] n, input [2:0] w);
        ad = 16'h8800 + {4'h0, n, w, 2'b00};
    endfunction
    // Pattern written to word w of entry n; upper half never zero
    function [31:0] wd(input [6:0] n, input [2:0] w);
        wd = {n, w, 6'h2A, n, w, 6'h15};
    endfunction
    // Value a read should return after load
    function [31:0] ex(input [6:0] n, input [2:0] w, input [2:0] c, input v);
        case (w)
            3'h1, 3'h3: ex = wd(n, w) & 32'h0000FFFF;
            3'h5: ex = {29'h0, c};
            3'h7: ex = (wd(n, w) & 32'h00007FFF) | {16'h0000, v, 15'h0000};
            default: ex = wd(n, w);
        endcase
    endfunction
    function [7:0] lenof(input [2:0] c);
        lenof = (c == 3'h0) ? 8'h28 : (c == 3'h1) ? 8'h68 :
                (c == 3'h2 || c == 3'h7) ? 8'h00 : 8'h80;
    endfunction
    // Expected key and station address outputs of entry n
    function [127:0] kx(input [6:0] n);
        reg [31:0] a;
        reg [31:0] b;
        begin
            a = wd(n, 3'h3);
            b = wd(n, 3'h1);
            kx = {wd(n, 3'h4), a[15:0], wd(n, 3'h2), b[15:0], wd(n, 3'h0)};
        end
    endfunction
    function [47:0] mx(input [6:0] n);
        reg [31:0] a;
        begin
            a = wd(n, 3'h7);
            mx = {a[14:0], wd(n, 3'h6), 1'b0};
        end
    endfunction

    task chk(input [127:0] g, input [127:0] e);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [15:0] a, input [31:0] d);
        begin
            @(posedge i_mclk);
            i_reg_wr <= 1'b1;
            i_reg_addr <= a;
            i_reg_wdata <= d;
            @(posedge i_mclk);
            i_reg_wr <= 1'b0;
        end
    endtask
    task rdc(input [15:0] a, input [31:0] e);
        begin
            @(posedge i_mclk);
            i_reg_rd <= 1'b1;
            i_reg_addr <= a;
            @(posedge i_mclk);
            i_reg_rd <= 1'b0;
            #1;
            chk(o_reg_rvalid, 1'b1);
            chk(o_reg_rdata, e);
        end
    endtask
    // Fill all eight words of one entry, reserved bits written non-zero
    task load(input [6:0] n, input [2:0] c, input v);
        begin
            for (k = 0; k < 8; k = k + 1)
                wr(ad(n, k[2:0]), (k == 5) ? (wd(n, 3'h5) & 32'hFFFFFFF8) | {29'h0, c} :
                    (k == 7) ? (wd(n, 3'h7) & 32'hFFFF7FFF) | {16'h0, v, 15'h0} : wd(n, k[2:0]));
        end
    endtask
    // Same index on both lookup ports
    task lk(input [6:0] n);
        begin
            @(posedge i_mclk);
            i_tx_req <= 1'b1;
            i_rx_req <= 1'b1;
            i_tx_index <= n;
            i_rx_index <= n;
            @(posedge i_mclk);
            i_tx_req <= 1'b0;
            i_rx_req <= 1'b0;
            #1;
            chk({o_tx_rsp, o_rx_rsp}, 2'b11);
        end
    endtask

    // Reset values, unmapped and unaligned reads
    task s_reset;
        begin
            rdc(ad(7'h00, 3'h5), 32'h7);
            // Address bits of word 7 are not reset, so only bits 31-15 are judged
            @(posedge i_mclk);
            i_reg_rd <= 1'b1;
            i_reg_addr <= ad(7'h00, 3'h7);
            @(posedge i_mclk);
            i_reg_rd <= 1'b0;
            #1;
            chk({o_reg_rvalid, o_reg_rdata[31:15]}, 18'h20000);
            rdc(16'h8000, 32'h0);
            rdc(16'h8802, 32'h0);
        end
    endtask
    // Word layout of a valid entry and the last entry
    task s_layout;
        begin
            load(7'd63, 3'h3, 1'b1);
            for (k = 0; k < 8; k = k + 1)
                rdc(ad(7'd63, k[2:0]),
                    ex(7'd63, k[2:0], 3'h3, 1'b1));
            load(7'd127, 3'h6, 1'b1);
            rdc(ad(7'd127, 3'h0), wd(7'd127, 3'h0));
            rdc(ad(7'd127, 3'h7), ex(7'd127, 3'h7, 3'h6, 1'b0));
        end
    endtask
    // Every cipher code through both lookup ports
    task s_types;
        begin
            load(7'd69, 3'h0, 1'b0);
            for (t = 0; t < 8; t = t + 1) begin
                load(7'd5, t[2:0], 1'b1);
                lk(7'd5);
                h = (t != 2) && (t != 7);
                chk({o_tx_hit, o_rx_hit}, {h, h});
                chk({o_tx_ctype, o_rx_ctype}, h ? {t[2:0], t[2:0]} : 6'h3F);
                chk({o_tx_key_len, o_rx_key_len}, {lenof(t[2:0]), lenof(t[2:0])});
                chk(o_tx_key, h ? kx(7'd5) : 128'h0);
                chk(o_rx_key, h ? kx(7'd5) : 128'h0);
                chk({o_tx_mac, o_rx_mac}, h ? {mx(7'd5), mx(7'd5)} : 96'h0);
                chk({o_tx_tkip, o_rx_tkip}, (t == 4) ? 2'b11 : 2'b00);
                chk({o_tx_mic0, o_tx_mic1, o_rx_mic0, o_rx_mic1}, (t == 4) ?
                    {wd(7'd69, 3'h0), wd(7'd69, 3'h2), wd(7'd69, 3'h0), wd(7'd69, 3'h2)} : 128'h0);
            end
        end
    endtask
    // Cleared valid flag and a TKIP key in the upper half both miss
    task s_misses;
        begin
            load(7'd5, 3'h3, 1'b0);
            lk(7'd5);
            chk({o_tx_hit, o_rx_hit}, 2'b00);
            chk(o_tx_key, 128'h0);
            load(7'd70, 3'h4, 1'b1);
            lk(7'd70);
            chk({o_tx_hit, o_tx_tkip, o_rx_mic0}, 34'h0);
        end
    endtask

    // A write taken while the clock enable is low leaves the entry unchanged
    task s_freeze;
        begin
            @(posedge i_mclk);
            i_ce <= 1'b0;
            wr(ad(7'd5, 3'h0), 32'h0);
            i_ce <= 1'b1;
            rdc(ad(7'd5, 3'h0), wd(7'd5, 3'h0));
        end
    endtask

    task stop_test;
        begin
            if (n_fail == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge i_mclk);
        i_reset <= 1'b0;
        s_reset;
        s_layout;
        s_types;
        s_misses;
        s_freeze;
        stop_test;
    end
    // Hang guard
    initial begin
        #400000;
        n_fail = n_fail + 1;
        stop_test;
    end
endmodule
